// [hdl/oag_top.sv]
// oag_top: operand address generator for an 8/16-bit core
// assumes instruction fields arrive decoded from fetch; memory answers
// a read with rd_valid_i on the same clock domain
//
// Overview of operation
// - word data accesses force address bit 0 to zero.
// - fetch addresses and branch targets are also forced even.
// - condition codes pushed into both bytes; restore uses upper byte only.
// - post-increment uses register then add_small_word 1 byte or 2 word.
// - pre-decrement subtracts 1 or 2, uses and keeps the result.
// - displacement mode add_small_word 16-bit second word to the register.
// - displacement only for moves; software keeps word addresses even.
// - post-increment for loads, pre-decrement for stores.
// - 8-bit absolute address gets upper byte all ones.
// - memory indirect zero-extends and fetches target word there.
// - relative branch sign-extends byte 2 and add_small_word to program counter.
// - 8-bit immediate in byte 2, 16-bit in bytes 3-4, word move only.
// - add/subtract small carry implied immediate 1 or 2.
// - bit number is a 3-bit field in byte 2 or byte 4.
// - bit ops use direct, indirect or absolute; some take register bit number.
// - word operands only for the listed word instructions.
// - decimal adjust after add or subtract on packed bcd bytes.
// - packed bcd has upper digit in 7:4, lower in 3:0.
// - transfers allow all but relative and indirect; alu uses register direct. code also rejects 8-bit absolute for word moves.
// - immediate also for byte add, extend ops, byte compare, and/or/xor.
// - register seven is the stack pointer for calls and exceptions. code uses it only for ccr push and pop.
`timescale 1ns/1ps
module oag_top import oag_pkg::*; (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // decoded instruction
  input wire logic req_i,
  input wire oag_op_e op_i,
  input wire oag_mode_e mode_i,
  input wire logic word_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [15:0] ext_word_i,
  input wire logic [7:0] byte2_i,
  input wire logic [7:0] byte4_i,
  input wire logic bitnum_hi_i,
  input wire logic bitnum_reg_i,
  input wire logic small_two_i,
  input wire logic [AW-1:0] pc_i,
  // register file
  input wire logic [AW-1:0] reg_val_i,
  input wire logic [7:0] bit_reg_i,
  input wire logic [7:0] ccr_i,
  input wire logic [DW-1:0] wdata_i,
  // bcd adjust operand
  input wire logic [7:0] bcd_val_i,
  input wire logic bcd_carry_i,
  input wire logic bcd_half_i,
  // memory read answer
  input wire logic rd_valid_i,
  input wire logic [DW-1:0] rd_data_i,
  // memory request
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_word_o,
  output logic [AW-1:0] mem_addr_o,
  output logic [DW-1:0] mem_wdata_o,
  // results
  output logic done_o,
  output logic illegal_o,
  output logic [AW-1:0] ea_o,
  output logic [AW-1:0] target_o,
  output logic target_valid_o,
  output logic [AW-1:0] fetch_addr_o,
  output logic reg_wr_o,
  output logic [2:0] reg_wr_sel_o,
  output logic [AW-1:0] reg_wr_val_o,
  output logic [15:0] imm_o,
  output logic [BITNUM_W-1:0] bitnum_o,
  output logic [7:0] ccr_restore_o,
  output logic [7:0] bcd_res_o,
  output logic bcd_carry_o
);

  typedef struct packed {
    oag_state_e st;
    logic mem_req;
    logic mem_we;
    logic mem_word;
    logic [AW-1:0] mem_addr;
    logic [DW-1:0] mem_wdata;
    logic done;
    logic illegal;
    logic [AW-1:0] ea;
    logic [AW-1:0] target;
    logic target_valid;
    logic [AW-1:0] fetch_addr;
    logic reg_wr;
    logic [2:0] reg_wr_sel;
    logic [AW-1:0] reg_wr_val;
    logic [15:0] imm;
    logic [BITNUM_W-1:0] bitnum;
    logic [7:0] ccr_restore;
    logic [7:0] bcd_res;
    logic bcd_carry;
    logic pend_pop;
  } oag_state_s;

  oag_state_s s_r;
  oag_state_s s_nxt;

  logic [AW-1:0] calc_ea;
  logic [AW-1:0] calc_reg;
  logic calc_wr;
  logic [7:0] adj_res;
  logic adj_carry;
  oag_mode_e eff_mode;
  logic eff_word;

  // word operand classes
  function automatic logic is_word_op(input oag_op_e op);
    is_word_op = (op == OP_WORD_MOVE) || (op == OP_WORD_ADD) || (op == OP_WORD_SUB)
      || (op == OP_WORD_COMPARE) || (op == OP_ADD_SMALL) || (op == OP_SUB_SMALL)
      || (op == OP_UMUL) || (op == OP_UDIV) || (op == OP_CCR_PUSH) || (op == OP_CCR_POP);
  endfunction

  function automatic logic is_bit_op(input oag_op_e op);
    is_bit_op = (op == OP_BIT_SET) || (op == OP_BIT_CLEAR) || (op == OP_BIT_INVERT)
      || (op == OP_BIT_TEST) || (op == OP_BIT_OTHER);
  endfunction

  function automatic logic is_move(input oag_op_e op);
    is_move = (op == OP_BYTE_MOVE) || (op == OP_WORD_MOVE);
  endfunction

  // legality of a mode for a class
  function automatic logic mode_ok(input oag_op_e op, input oag_mode_e m, input logic w);
    mode_ok = 1'b0;
    if (is_move(op)) begin
      // transfers: all but relative and indirect, and no 8-bit absolute for words or 16-bit immediate for bytes
      mode_ok = (m != AM_PC_REL) && (m != AM_MEM_IND);
      if (m == AM_ABS8 && w) mode_ok = 1'b0;
      if (m == AM_IMM16 && !w) mode_ok = 1'b0;
    end else if (is_bit_op(op)) begin
      mode_ok = (m == AM_REG_DIRECT) || (m == AM_REG_IND) || (m == AM_ABS8) || (m == AM_ABS16);
    end else if (op == OP_JUMP || op == OP_SUBR_CALL) begin
      mode_ok = (m == AM_REG_IND) || (m == AM_ABS16) || (m == AM_MEM_IND);
    end else if (op == OP_BRANCH || op == OP_REL_SUBR_CALL) begin
      mode_ok = (m == AM_PC_REL);
    end else if (op == OP_CCR_PUSH) begin
      mode_ok = (m == AM_PRE_DEC);
    end else if (op == OP_CCR_POP) begin
      mode_ok = (m == AM_POST_INC);
    end else if (op == OP_BYTE_ADD || op == OP_ADD_EXTEND || op == OP_SUB_EXTEND
      || op == OP_BYTE_COMPARE || op == OP_AND || op == OP_OR || op == OP_XOR) begin
      mode_ok = (m == AM_REG_DIRECT) || (m == AM_IMM8);
    end else begin
      mode_ok = (m == AM_REG_DIRECT);
    end
  endfunction

  // stack pushes and pops go through register seven
  always_comb begin
    eff_mode = mode_i;
    if (op_i == OP_CCR_PUSH) eff_mode = AM_PRE_DEC;
    if (op_i == OP_CCR_POP) eff_mode = AM_POST_INC;
  end

  // word size only for the listed classes
  assign eff_word = is_word_op(op_i) && (is_move(op_i) ? word_i : 1'b1);

  oag_addr_calc u_calc (
    .mode_i(eff_mode),
    .word_i(eff_word),
    .reg_val_i(reg_val_i),
    .pc_i(pc_i),
    .ext_word_i(ext_word_i),
    .byte2_i(byte2_i),
    .ea_o(calc_ea),
    .reg_new_o(calc_reg),
    .reg_wr_o(calc_wr)
  );

  oag_bcd_adj u_bcd (
    .val_i(bcd_val_i),
    .sub_i(op_i == OP_DEC_ADJ_SUB),
    .carry_i(bcd_carry_i),
    .half_i(bcd_half_i),
    .res_o(adj_res),
    .carry_o(adj_carry)
  );

  always_comb begin
    logic legal;
    logic is_store;
    legal = 1'b0;
    is_store = 1'b0;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.mem_req = 1'b0;
    s_nxt.target_valid = 1'b0;
    s_nxt.reg_wr = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (req_i) begin
          legal = mode_ok(op_i, eff_mode, eff_word);
          // loads read into a register, stores write from one
          is_store = (eff_mode == AM_PRE_DEC);
          s_nxt.illegal = !legal;
          s_nxt.ea = calc_ea;
          s_nxt.mem_word = eff_word;
          s_nxt.mem_wdata = wdata_i; // upper byte at even address
          s_nxt.imm = 16'h0000;
          s_nxt.pend_pop = 1'b0;
          if (mode_i == AM_IMM8) s_nxt.imm = {8'h00, byte2_i};
          if (mode_i == AM_IMM16) s_nxt.imm = ext_word_i;
          if (op_i == OP_ADD_SMALL || op_i == OP_SUB_SMALL) begin
            s_nxt.imm = small_two_i ? STEP_WORD : STEP_BYTE;
          end
          s_nxt.bitnum = bitnum_reg_i ? bit_reg_i[BITNUM_W-1:0]
            : (bitnum_hi_i ? byte4_i[BITNUM_W-1:0] : byte2_i[BITNUM_W-1:0]);
          if (op_i == OP_DEC_ADJ_ADD || op_i == OP_DEC_ADJ_SUB) begin
            s_nxt.bcd_res = adj_res;
            s_nxt.bcd_carry = adj_carry;
          end
          s_nxt.fetch_addr = {pc_i[AW-1:1], 1'b0};
          if (!legal) begin
            s_nxt.st = ST_DONE;
          end else if (op_i == OP_CCR_PUSH) begin
            s_nxt.mem_req = 1'b1;
            s_nxt.mem_we = 1'b1;
            s_nxt.mem_addr = calc_ea;
            s_nxt.mem_wdata = {ccr_i, ccr_i};
            s_nxt.reg_wr = 1'b1;
            s_nxt.reg_wr_sel = SP_INDEX;
            s_nxt.reg_wr_val = calc_reg;
            s_nxt.st = ST_DONE;
          end else if (op_i == OP_CCR_POP) begin
            s_nxt.mem_req = 1'b1;
            s_nxt.mem_we = 1'b0;
            s_nxt.mem_addr = calc_ea;
            s_nxt.reg_wr = 1'b1;
            s_nxt.reg_wr_sel = SP_INDEX;
            s_nxt.reg_wr_val = calc_reg;
            s_nxt.pend_pop = 1'b1;
            s_nxt.st = ST_VFECH;
          end else if (eff_mode == AM_MEM_IND) begin
            s_nxt.mem_req = 1'b1;
            s_nxt.mem_we = 1'b0;
            s_nxt.mem_word = 1'b1;
            s_nxt.mem_addr = calc_ea;
            s_nxt.st = ST_VFECH;
          end else begin
            if (op_i == OP_BRANCH || op_i == OP_REL_SUBR_CALL || op_i == OP_JUMP
              || op_i == OP_SUBR_CALL) begin
              s_nxt.target = {calc_ea[AW-1:1], 1'b0};
              s_nxt.target_valid = 1'b1;
            end else if (eff_mode inside {[AM_REG_IND:AM_ABS16]}) begin
              s_nxt.mem_req = 1'b1;
              s_nxt.mem_we = is_store;
              s_nxt.mem_addr = calc_ea;
            end
            if (calc_wr) begin
              s_nxt.reg_wr = 1'b1;
              s_nxt.reg_wr_sel = reg_sel_i;
              s_nxt.reg_wr_val = calc_reg;
            end
            s_nxt.st = ST_DONE;
          end
        end
      end
      ST_VFECH: begin
        if (rd_valid_i) begin
          if (s_r.pend_pop) begin
            s_nxt.ccr_restore = rd_data_i[15:8]; // lower byte ignored
          end else begin
            s_nxt.target = {rd_data_i[AW-1:1], 1'b0};
            s_nxt.target_valid = 1'b1;
          end
          s_nxt.st = ST_DONE;
        end
      end
      ST_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.st = ST_IDLE;
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mem_req_o = s_r.mem_req;
  assign mem_we_o = s_r.mem_we;
  assign mem_word_o = s_r.mem_word;
  assign mem_addr_o = s_r.mem_addr;
  assign mem_wdata_o = s_r.mem_wdata;
  assign done_o = s_r.done;
  assign illegal_o = s_r.illegal;
  assign ea_o = s_r.ea;
  assign target_o = s_r.target;
  assign target_valid_o = s_r.target_valid;
  assign fetch_addr_o = s_r.fetch_addr;
  assign reg_wr_o = s_r.reg_wr;
  assign reg_wr_sel_o = s_r.reg_wr_sel;
  assign reg_wr_val_o = s_r.reg_wr_val;
  assign imm_o = s_r.imm;
  assign bitnum_o = s_r.bitnum;
  assign ccr_restore_o = s_r.ccr_restore;
  assign bcd_res_o = s_r.bcd_res;
  assign bcd_carry_o = s_r.bcd_carry;

endmodule // oag_top

// [hdl/oag_pkg.sv]
// oag_pkg: shared constants and types for the operand address generator
// assumes one core clock; no software-visible registers
package oag_pkg;

  localparam int AW = 16;
  localparam int DW = 16;

  // addressing modes (table of eleven)
  typedef enum logic [3:0] {
    AM_REG_DIRECT = 4'h0,
    AM_REG_IND    = 4'h1,
    AM_DISP16     = 4'h2,
    AM_POST_INC   = 4'h3,
    AM_PRE_DEC    = 4'h4,
    AM_ABS8       = 4'h5,
    AM_ABS16      = 4'h6,
    AM_IMM8       = 4'h7,
    AM_IMM16      = 4'h8,
    AM_PC_REL     = 4'h9,
    AM_MEM_IND    = 4'hA
  } oag_mode_e;

  // instruction classes the checker needs
  typedef enum logic [4:0] {
    OP_BYTE_MOVE      = 5'h00,
    OP_WORD_MOVE      = 5'h01,
    OP_BYTE_ADD       = 5'h02,
    OP_WORD_ADD       = 5'h03,
    OP_BYTE_SUB       = 5'h04,
    OP_WORD_SUB       = 5'h05,
    OP_BYTE_COMPARE   = 5'h06,
    OP_WORD_COMPARE   = 5'h07,
    OP_ADD_EXTEND     = 5'h08,
    OP_SUB_EXTEND     = 5'h09,
    OP_ADD_SMALL      = 5'h0A,
    OP_SUB_SMALL      = 5'h0B,
    OP_UMUL           = 5'h0C,
    OP_UDIV           = 5'h0D,
    OP_AND            = 5'h0E,
    OP_OR             = 5'h0F,
    OP_XOR            = 5'h10,
    OP_OTHER_ALU      = 5'h11,
    OP_BIT_SET        = 5'h12,
    OP_BIT_CLEAR      = 5'h13,
    OP_BIT_INVERT     = 5'h14,
    OP_BIT_TEST       = 5'h15,
    OP_BIT_OTHER      = 5'h16,
    OP_JUMP           = 5'h17,
    OP_SUBR_CALL      = 5'h18,
    OP_BRANCH         = 5'h19,
    OP_REL_SUBR_CALL  = 5'h1A,
    OP_DEC_ADJ_ADD    = 5'h1B,
    OP_DEC_ADJ_SUB    = 5'h1C,
    OP_CCR_PUSH       = 5'h1D,
    OP_CCR_POP        = 5'h1E
  } oag_op_e;

  // fsm: idle, fetch indirect vector, done
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_VFECH = 2'b01,
    ST_DONE  = 2'b11
  } oag_state_e;

  localparam logic [7:0] ABS8_UPPER = 8'hFF;
  localparam logic [7:0] MIND_UPPER = 8'h00;
  localparam logic [AW-1:0] STEP_BYTE = 16'h0001;
  localparam logic [AW-1:0] STEP_WORD = 16'h0002;
  localparam logic [2:0] SP_INDEX = 3'h7;
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [3:0] BCD_ADJ = 4'h6;
  localparam logic [3:0] BCD_ADJ_NEG = 4'hA;
  localparam logic [7:0] BCD_HI_ADJ = 8'h60;
  localparam logic [7:0] BCD_HI_ADJ_NEG = 8'hA0;
  localparam logic [7:0] BCD_HI_MAX = 8'h99;
  localparam int BITNUM_W = 3;

endpackage

// [hdl/oag_addr_calc.sv]
// oag_addr_calc: combinational effective address and register update
// assumes register value and instruction fields are stable for the cycle
`timescale 1ns/1ps
module oag_addr_calc import oag_pkg::*; (
  // request
  input wire oag_mode_e mode_i,
  input wire logic word_i,
  input wire logic [AW-1:0] reg_val_i,
  input wire logic [AW-1:0] pc_i,
  input wire logic [15:0] ext_word_i,
  input wire logic [7:0] byte2_i,
  // result
  output logic [AW-1:0] ea_o,
  output logic [AW-1:0] reg_new_o,
  output logic reg_wr_o
);

  logic [AW-1:0] step;
  logic [AW-1:0] raw;

  always_comb begin
    step = word_i ? STEP_WORD : STEP_BYTE;
    reg_new_o = reg_val_i;
    reg_wr_o = 1'b0;
    case (mode_i)
      AM_REG_IND: raw = reg_val_i;
      AM_DISP16: raw = reg_val_i + ext_word_i;
      AM_POST_INC: begin
        raw = reg_val_i;
        reg_new_o = reg_val_i + step;
        reg_wr_o = 1'b1;
      end
      AM_PRE_DEC: begin
        raw = reg_val_i - step;
        reg_new_o = reg_val_i - step;
        reg_wr_o = 1'b1;
      end
      AM_ABS8: raw = {ABS8_UPPER, byte2_i};
      AM_ABS16: raw = ext_word_i;
      AM_PC_REL: raw = pc_i + {{8{byte2_i[7]}}, byte2_i};
      AM_MEM_IND: raw = {MIND_UPPER, byte2_i};
      default: raw = reg_val_i;
    endcase
    // word accesses, relative branch targets and memory indirect pointers are even
    ea_o = (word_i || mode_i == AM_PC_REL || mode_i == AM_MEM_IND) ? {raw[AW-1:1], 1'b0} : raw;
  end

endmodule // oag_addr_calc

// [hdl/oag_bcd_adj.sv]
// oag_bcd_adj: packed bcd decimal adjust for add and subtract
// assumes carry and half-carry come from the preceding byte operation
`timescale 1ns/1ps
module oag_bcd_adj import oag_pkg::*; (
  // operand
  input wire logic [7:0] val_i,
  input wire logic sub_i,
  input wire logic carry_i,
  input wire logic half_i,
  // result
  output logic [7:0] res_o,
  output logic carry_o
);

  logic lo_fix;
  logic hi_fix;
  logic [7:0] adj;

  // upper digit bits 7:4, lower digit bits 3:0
  always_comb begin
    lo_fix = half_i || (!sub_i && (val_i[3:0] > BCD_MAX_DIGIT));
    hi_fix = carry_i || (!sub_i && (val_i > BCD_HI_MAX));
    adj = 8'h00;
    if (sub_i) begin
      if (lo_fix) adj[3:0] = BCD_ADJ_NEG;
      if (hi_fix) adj = adj + (lo_fix ? 8'h90 : BCD_HI_ADJ_NEG);
      if (lo_fix && !hi_fix) adj[7:4] = 4'hF;
    end else begin
      if (lo_fix) adj[3:0] = BCD_ADJ;
      if (hi_fix) adj[7:4] = BCD_HI_ADJ[7:4];
    end
    res_o = val_i + adj;
    carry_o = hi_fix;
  end

endmodule // oag_bcd_adj

// [sim/oag_mem_model.sv]
// oag_mem_model: memory and fetch side answering the block's reads
// assumes one read in flight; stores are accepted and dropped
`timescale 1ns/1ps
module oag_mem_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // request from the block
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic slow_i,
  // read answer
  output logic rd_valid_o,
  output logic [15:0] rd_data_o
);
  logic busy_r;
  logic [3:0] wait_r;
  logic [15:0] addr_r;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      addr_r <= 16'h0000;
      rd_valid_o <= 1'b0;
      rd_data_o <= 16'h0000;
    end else begin
      rd_valid_o <= 1'b0;
      // released bus keeps toggling so a stale value is never mistaken for data
      rd_data_o <= ~rd_data_o;
      if (req_i && !we_i) begin
        busy_r <= 1'b1;
        wait_r <= slow_i ? 4'h4 : 4'h0;
        addr_r <= addr_i;
      end else if (busy_r && wait_r == 4'h0) begin
        busy_r <= 1'b0;
        rd_valid_o <= 1'b1;
        // upper byte at addr, lower at addr + 1
        rd_data_o <= {addr_r[7:0] ^ 8'hC3, (addr_r[7:0] + 8'h01) ^ 8'hC3};
      end else if (busy_r) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule // oag_mem_model

// [sim/oag_chk.sv]
// oag_chk: port-level properties of the operand address generator
// assumes it is bound onto oag_top; one clock, async reset
`timescale 1ns/1ps
module oag_chk import oag_pkg::*; (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire oag_op_e op_i,
  input wire oag_mode_e mode_i,
  input wire logic word_i,
  input wire logic [7:0] byte2_i,
  input wire logic [AW-1:0] pc_i,
  input wire logic [AW-1:0] reg_val_i,
  input wire logic [7:0] ccr_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic mem_word_o,
  input wire logic [AW-1:0] mem_addr_o,
  input wire logic [DW-1:0] mem_wdata_o,
  input wire logic done_o,
  input wire logic illegal_o,
  input wire logic [AW-1:0] target_o,
  input wire logic target_valid_o,
  input wire logic [AW-1:0] fetch_addr_o,
  input wire logic reg_wr_o,
  input wire logic [AW-1:0] reg_wr_val_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire logic mv = (op_i == OP_BYTE_MOVE) || (op_i == OP_WORD_MOVE);
  wire logic [15:0] step = word_i ? 16'h0002 : 16'h0001;
  wire logic [15:0] rel = pc_i + {{8{byte2_i[7]}}, byte2_i};
  wire logic [15:0] post = reg_val_i + step;
  wire logic [15:0] pre = reg_val_i - step;
  word_even_a: assert property (mem_req_o && mem_word_o |-> !mem_addr_o[0])
    else $error("odd word address");
  branch_even_a: assert property (target_valid_o |-> !target_o[0])
    else $error("odd branch target");
  fetch_even_a: assert property (req_i |=> fetch_addr_o == ($past(pc_i) & 16'hFFFE))
    else $error("fetch address wrong");
  ccr_push_a: assert property (req_i && op_i == OP_CCR_PUSH |=>
    mem_req_o && mem_we_o && mem_wdata_o == {2{$past(ccr_i)}}) else $error("ccr push word wrong");
  post_inc_a: assert property (req_i && mv && mode_i == AM_POST_INC |=>
    reg_wr_o && reg_wr_val_o == $past(post)) else $error("post increment wrong");
  pre_dec_a: assert property (req_i && mv && mode_i == AM_PRE_DEC |=>
    reg_wr_o && mem_addr_o == $past(pre) && reg_wr_val_o == $past(pre)) else $error("pre decrement wrong");
  disp_only_a: assert property (req_i && !mv && mode_i == AM_DISP16 |=>
    !mem_req_o && !reg_wr_o ##1 done_o && illegal_o) else $error("displacement outside move");
  abs8_high_a: assert property (req_i && op_i == OP_BYTE_MOVE && mode_i == AM_ABS8 |=>
    mem_req_o && mem_addr_o == {8'hFF, $past(byte2_i)}) else $error("short absolute wrong");
  ind_zero_a: assert property (req_i && mode_i == AM_MEM_IND |=>
    mem_req_o && mem_addr_o[15:8] == 8'h00) else $error("indirect address not in low page");
  rel_target_a: assert property (req_i && op_i == OP_BRANCH && mode_i == AM_PC_REL |=>
    target_valid_o && target_o == ($past(rel) & 16'hFFFE)) else $error("relative target wrong");
  cover property (req_i && mode_i == AM_MEM_IND ##1 mem_req_o);
  cover property (target_valid_o ##1 done_o);
  cover property (done_o && illegal_o);
endmodule // oag_chk
bind oag_top oag_chk i_oag_chk (.clock_i, .reset_i, .req_i, .op_i, .mode_i, .word_i, .byte2_i, .pc_i,
  .reg_val_i, .ccr_i, .mem_req_o, .mem_we_o, .mem_word_o, .mem_addr_o, .mem_wdata_o, .done_o,
  .illegal_o, .target_o, .target_valid_o, .fetch_addr_o, .reg_wr_o, .reg_wr_val_o);

// [sim/oag_top_bench.sv]
// oag_top_bench: self-checking bench for the operand address generator
// assumes oag_mem_model answers reads; inputs change on falling edges
`timescale 1ns/1ps
module oag_top_bench import oag_pkg::*; ;
  logic clock_i, reset_i, req_i, word_i, bitnum_hi_i, bitnum_reg_i, small_two_i, slow;
  oag_op_e op_i;
  oag_mode_e mode_i;
  logic [2:0] reg_sel_i, reg_wr_sel_o, bitnum_o, s_wsel;
  logic [15:0] ext_word_i, pc_i, reg_val_i, wdata_i, rd_data_i;
  logic [7:0] byte2_i, byte4_i, bit_reg_i, ccr_i, bcd_val_i, ccr_restore_o, bcd_res_o;
  logic bcd_carry_i, bcd_half_i, rd_valid_i, mem_req_o, mem_we_o, mem_word_o, done_o, illegal_o;
  logic target_valid_o, reg_wr_o, bcd_carry_o, s_mem, s_we, s_wr, s_tg;
  logic [15:0] mem_addr_o, mem_wdata_o, ea_o, target_o, fetch_addr_o, reg_wr_val_o, imm_o;
  logic [15:0] s_addr, s_wd, s_wval, s_tgt;
  int error_cnt = 0;
  int compares = 0;
  oag_top i_oag_top (.clock_i, .reset_i, .req_i, .op_i, .mode_i, .word_i, .reg_sel_i, .ext_word_i,
    .byte2_i, .byte4_i, .bitnum_hi_i, .bitnum_reg_i, .small_two_i, .pc_i, .reg_val_i, .bit_reg_i,
    .ccr_i, .wdata_i, .bcd_val_i, .bcd_carry_i, .bcd_half_i, .rd_valid_i, .rd_data_i, .mem_req_o,
    .mem_we_o, .mem_word_o, .mem_addr_o, .mem_wdata_o, .done_o, .illegal_o, .ea_o, .target_o,
    .target_valid_o, .fetch_addr_o, .reg_wr_o, .reg_wr_sel_o, .reg_wr_val_o, .imm_o, .bitnum_o,
    .ccr_restore_o, .bcd_res_o, .bcd_carry_o);
  oag_mem_model i_oag_mem_model (.clock_i, .reset_i, .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .slow_i(slow), .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ 8'hC3;
  endfunction
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one-cycle pulses are caught on the falling edge
  always @(negedge clock_i) begin
    if (mem_req_o === 1'b1) begin
      s_mem = 1'b1;
      s_we = mem_we_o;
      s_addr = mem_addr_o;
      s_wd = mem_wdata_o;
    end
    if (reg_wr_o === 1'b1) begin
      s_wr = 1'b1;
      s_wval = reg_wr_val_o;
      s_wsel = reg_wr_sel_o;
    end
    if (target_valid_o === 1'b1) begin
      s_tg = 1'b1;
      s_tgt = target_o;
    end
  end
  task automatic go(input oag_op_e op, input oag_mode_e md, input logic w, input logic [15:0] rv,
                    input logic [7:0] b2);
    int n;
    @(negedge clock_i);
    op_i = op;
    mode_i = md;
    word_i = w;
    reg_val_i = rv;
    byte2_i = b2;
    {s_mem, s_we, s_wr, s_tg} = 4'h0;
    req_i = 1'b1;
    @(negedge clock_i);
    req_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    chk("done", done_o, 16'h0001);
  endtask
  task automatic t_step;
    logic [15:0] rv, st;
    for (int w = 0; w < 2; w++) begin
      rv = w ? 16'h2000 : 16'h2001; // word base kept even
      st = w ? 16'h0002 : 16'h0001;
      go(w ? OP_WORD_MOVE : OP_BYTE_MOVE, AM_POST_INC, w[0], rv, 8'h00);
      chk("post addr", s_addr, rv);
      chk("post reg", s_wval, rv + st);
      chk("post load", {s_we, s_wr}, 16'h0001);
      go(w ? OP_WORD_MOVE : OP_BYTE_MOVE, AM_PRE_DEC, w[0], 16'h3000, 8'h00);
      chk("pre addr", s_addr, 16'h3000 - st);
      chk("pre reg", s_wval, 16'h3000 - st);
      chk("pre store", s_we, 16'h0001);
    end
    $display("t_step finished");
  endtask
  task automatic t_disp_abs;
    ext_word_i = 16'h0FFF;
    go(OP_WORD_MOVE, AM_DISP16, 1'b1, 16'h1000, 8'h00);
    chk("disp word", s_addr, 16'h1FFE);
    chk("disp size", mem_word_o, 16'h0001);
    go(OP_BYTE_MOVE, AM_DISP16, 1'b0, 16'h1000, 8'h00);
    chk("disp byte", s_addr, 16'h1FFF);
    go(OP_BYTE_ADD, AM_DISP16, 1'b0, 16'h1000, 8'h00);
    chk("disp alu", {illegal_o, s_mem}, 16'h0002);
    go(OP_BYTE_MOVE, AM_ABS8, 1'b0, 16'h0000, 8'h34);
    chk("abs8", s_addr, 16'hFF34);
    chk("abs8 ea", ea_o, 16'hFF34);
    go(OP_WORD_MOVE, AM_ABS8, 1'b1, 16'h0000, 8'h34);
    chk("abs8 word", illegal_o, 16'h0001);
    $display("t_disp_abs finished");
  endtask
  task automatic t_imm;
    oag_op_e ops[7] = '{OP_BYTE_ADD, OP_ADD_EXTEND, OP_SUB_EXTEND, OP_BYTE_COMPARE, OP_AND, OP_OR, OP_XOR};
    go(OP_BYTE_MOVE, AM_IMM8, 1'b0, 16'h0000, 8'hA7);
    chk("imm8", imm_o[7:0], 16'h00A7);
    ext_word_i = 16'hBEEF;
    go(OP_WORD_MOVE, AM_IMM16, 1'b1, 16'h0000, 8'h00);
    chk("imm16", imm_o, 16'hBEEF);
    go(OP_BYTE_MOVE, AM_IMM16, 1'b0, 16'h0000, 8'h00);
    chk("imm16 byte", illegal_o, 16'h0001);
    foreach (ops[i]) begin
      go(ops[i], AM_IMM8, 1'b0, 16'h0000, 8'h01);
      chk("imm alu", illegal_o, 16'h0000);
    end
    go(OP_BYTE_SUB, AM_IMM8, 1'b0, 16'h0000, 8'h01);
    chk("imm sub", illegal_o, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      small_two_i = k[0];
      go(k ? OP_SUB_SMALL : OP_ADD_SMALL, AM_REG_DIRECT, 1'b1, 16'h0000, 8'h00);
      chk("small imm", imm_o, k ? 16'h0002 : 16'h0001);
    end
    $display("t_imm finished");
  endtask
  task automatic t_bit_branch;
    for (int k = 0; k < 3; k++) begin
      bitnum_hi_i = (k == 1);
      bitnum_reg_i = (k == 2);
      go(OP_BIT_SET, AM_REG_DIRECT, 1'b0, 16'h0000, 8'h0D);
      chk("bit number", bitnum_o, k == 0 ? 16'h0005 : k == 1 ? 16'h0002 : 16'h0006);
    end
    go(OP_BIT_TEST, AM_DISP16, 1'b0, 16'h0000, 8'h01);
    chk("bit mode", illegal_o, 16'h0001);
    pc_i = 16'h1000;
    go(OP_BRANCH, AM_PC_REL, 1'b0, 16'h0000, 8'h80); // even displacement
    chk("rel back", s_tgt, 16'h0F80);
    chk("rel valid", s_tg, 16'h0001);
    pc_i = 16'h1001;
    go(OP_REL_SUBR_CALL, AM_PC_REL, 1'b0, 16'h0000, 8'h7E);
    chk("rel fwd", s_tgt, 16'h107E);
    chk("fetch", fetch_addr_o, 16'h1000);
    go(OP_WORD_MOVE, AM_PC_REL, 1'b1, 16'h0000, 8'h02);
    chk("rel move", illegal_o, 16'h0001);
    go(OP_BYTE_ADD, AM_REG_IND, 1'b0, 16'h0000, 8'h00);
    chk("alu ind", illegal_o, 16'h0001);
    $display("t_bit_branch finished");
  endtask
  task automatic t_ind_ccr;
    slow = 1'b1;
    go(OP_JUMP, AM_MEM_IND, 1'b0, 16'h0000, 8'h11);
    chk("ind addr", s_addr, 16'h0010);
    chk("ind target", s_tgt, {mb(16'h0010), mb(16'h0011)} & 16'hFFFE);
    slow = 1'b0;
    go(OP_SUBR_CALL, AM_MEM_IND, 1'b0, 16'h0000, 8'hFE);
    chk("ind top", s_tgt, {mb(16'h00FE), mb(16'h00FF)} & 16'hFFFE);
    ccr_i = 8'h8B;
    go(OP_CCR_PUSH, AM_REG_DIRECT, 1'b1, 16'h4000, 8'h00); // word access on the stack
    chk("push addr", s_addr, 16'h3FFE);
    chk("push data", s_wd, 16'h8B8B);
    chk("push sp", {13'h0000, s_wsel}, 16'h0007);
    go(OP_CCR_POP, AM_REG_DIRECT, 1'b1, 16'h4000, 8'h00);
    chk("pop addr", s_addr, 16'h4000);
    chk("pop ccr", ccr_restore_o, mb(16'h4000));
    chk("pop sp", s_wval, 16'h4002);
    $display("t_ind_ccr finished");
  endtask
  task automatic t_bcd;
    logic [7:0] v[3] = '{8'h0A, 8'h9A, 8'h13};
    logic [7:0] r[3] = '{8'h10, 8'h00, 8'h19};
    for (int k = 0; k < 3; k++) begin
      bcd_val_i = v[k];
      bcd_half_i = (k == 2);
      go(OP_DEC_ADJ_ADD, AM_REG_DIRECT, 1'b0, 16'h0000, 8'h00);
      chk("bcd res", bcd_res_o, r[k]);
      chk("bcd carry", bcd_carry_o, k == 1 ? 16'h0001 : 16'h0000);
    end
    $display("t_bcd finished");
  endtask
  initial begin
    #100us;
    error_cnt++;
    $display("watchdog expired");
    report_and_stop;
  end
  initial begin
    {reset_i, req_i, word_i, bitnum_hi_i, bitnum_reg_i, small_two_i, slow} = 7'h41;
    op_i = OP_BYTE_MOVE;
    mode_i = AM_REG_DIRECT;
    {reg_sel_i, ext_word_i, pc_i, reg_val_i, byte2_i, byte4_i} = 67'h0;
    {bit_reg_i, ccr_i, bcd_val_i, bcd_carry_i, bcd_half_i} = 26'h0;
    byte4_i = 8'h32;
    bit_reg_i = 8'hF6;
    wdata_i = 16'h5AA5;
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    reset_i = 1'b0;
    t_step;
    t_disp_abs;
    t_imm;
    t_bit_branch;
    t_ind_ccr;
    t_bcd;
    report_and_stop;
  end
endmodule // oag_top_bench
